// [src/nptx_consts.svh]
`ifndef NPTX_CONSTS_SVH
`define NPTX_CONSTS_SVH
`define NPTX_REG_ADDR 5'h07
`define NPTX_RESET_VAL 16'h2001
`define NPTX_BIT_MORE 15
`define NPTX_BIT_RSVD 14
`define NPTX_BIT_FMT 13
`define NPTX_BIT_SECOND_ACKNOWLEDGE 12
`define NPTX_BIT_TOGGLE 11
`define NPTX_CODE_MSB 10
`define NPTX_WR_MASK 16'hb7ff
`endif

// [src/nptx_pkg.sv]
package nptx_pkg;
	typedef enum logic [1:0] {
		NPTX_IDLE = 2'b00,
		NPTX_SEND = 2'b01
	} nptx_state_t;
endpackage : nptx_pkg

// [src/nptx_next_page_tx.sv]
// Notes on behaviour
// - outgoing next page word is built from the register at management address 7.
// - more pages flag in the sent word follows register bit 15.
// - next pages go out only when the partner is next page able.
// - bit 14 is reserved and always reads zero.
// - page format flag in the sent word follows register bit 13.
// - second acknowledge flag in the sent word follows register bit 12.
// - toggle bit 11 is read-only, inverts for each sent word, goes out.
// - first next page toggle is the complement of base page bit 11.
// - bits 10 to 0 are copied unchanged into the sent word.
`timescale 1ns/1ps
`default_nettype none
`include "nptx_consts.svh"
module nptx_next_page_tx
	import nptx_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [4:0] mgmtAddr,
	input wire logic mgmtWrite,
	input wire logic mgmtRead,
	input wire logic [15:0] mgmtWrData,
	output logic [15:0] mgmtRdData,
	output logic mgmtRdValid,
	input wire logic partnerNextPageAble,
	input wire logic basePageSent,
	input wire logic basePageBit11,
	input wire logic pageRequest,
	input wire logic pageDone,
	output logic [15:0] txPageWord,
	output logic txPageValid
);

////////////////////////////////////////////////////////////////////////////////
// reset release
logic rstSync1_q;
logic rstSync2_q;
always_ff @(posedge sys_clk or negedge reset_n) begin
	if (!reset_n) begin
		rstSync1_q <= 1'b0;
		rstSync2_q <= 1'b0;
	end else begin
		rstSync1_q <= 1'b1;
		rstSync2_q <= rstSync1_q;
	end
end
wire logic rstN = rstSync2_q;

////////////////////////////////////////////////////////////////////////////////
// state of the block
nptx_state_t state_q;
nptx_state_t state_d;
logic [15:0] regWord_q;
logic [15:0] regWord_d;
logic toggle_q;
logic toggle_d;
logic [15:0] txWord_q;
logic [15:0] txWord_d;
logic txValid_q;
logic txValid_d;
logic [15:0] rdData_q;
logic [15:0] rdData_d;
logic rdValid_q;
logic rdValid_d;
logic regHit;
logic pageStart;
logic pageEnd;
logic [15:0] regView;
logic [15:0] nextWord;

// decodes shared by several groups
// only this address is decoded here; neighbours answer zero
assign regHit = (mgmtAddr == `NPTX_REG_ADDR);
assign pageStart = (state_q == NPTX_IDLE) && pageRequest && partnerNextPageAble;
assign pageEnd = (state_q == NPTX_SEND) && pageDone;

////////////////////////////////////////////////////////////////////////////////
// register as management reads it and as the next page would carry it
always_comb begin
	regView = regWord_q;
	regView[`NPTX_BIT_RSVD] = 1'b0;
	regView[`NPTX_BIT_TOGGLE] = toggle_q;
end

always_comb begin
	nextWord = 16'h0000;
	nextWord[`NPTX_BIT_MORE] = regWord_q[`NPTX_BIT_MORE];
	nextWord[`NPTX_BIT_RSVD] = 1'b0;
	nextWord[`NPTX_BIT_FMT] = regWord_q[`NPTX_BIT_FMT];
	nextWord[`NPTX_BIT_SECOND_ACKNOWLEDGE] = regWord_q[`NPTX_BIT_SECOND_ACKNOWLEDGE];
	nextWord[`NPTX_BIT_TOGGLE] = toggle_q;
	nextWord[`NPTX_CODE_MSB:0] = regWord_q[`NPTX_CODE_MSB:0];
end

////////////////////////////////////////////////////////////////////////////////
// management register: writable fields only
always_comb begin
	regWord_d = regWord_q;
	// reserved and toggle bits are never stored from a write
	if (mgmtWrite && regHit) begin
		regWord_d = mgmtWrData & `NPTX_WR_MASK;
	end
end

always_ff @(posedge sys_clk or negedge rstN) begin
	if (!rstN) begin
		regWord_q <= `NPTX_RESET_VAL;
	end else begin
		regWord_q <= regWord_d;
	end
end

////////////////////////////////////////////////////////////////////////////////
// toggle: holds the value the next sent word will carry
always_comb begin
	toggle_d = toggle_q;
	if (pageEnd) begin
		toggle_d = ~toggle_q;
	end
	// base page wins over a page end: a new exchange restarts the sequence
	if (basePageSent) begin
		toggle_d = ~basePageBit11;
	end
end

always_ff @(posedge sys_clk or negedge rstN) begin
	if (!rstN) begin
		toggle_q <= 1'b0;
	end else begin
		toggle_q <= toggle_d;
	end
end

////////////////////////////////////////////////////////////////////////////////
// read port: one-cycle valid, data held until the next read
always_comb begin
	rdData_d = rdData_q;
	rdValid_d = 1'b0;
	if (mgmtRead && regHit) begin
		rdData_d = regView;
		rdValid_d = 1'b1;
	end else if (mgmtRead) begin
		// other addresses belong to neighbouring registers
		rdData_d = 16'h0000;
		rdValid_d = 1'b1;
	end
end

always_ff @(posedge sys_clk or negedge rstN) begin
	if (!rstN) begin
		rdData_q <= 16'h0000;
		rdValid_q <= 1'b0;
	end else begin
		rdData_q <= rdData_d;
		rdValid_q <= rdValid_d;
	end
end

////////////////////////////////////////////////////////////////////////////////
// transmit sequencer
always_comb begin
	state_d = state_q;
	unique case (state_q)
		NPTX_IDLE: begin
			if (pageStart) begin
				state_d = NPTX_SEND;
			end
		end
		NPTX_SEND: begin
			if (pageDone) begin
				state_d = NPTX_IDLE;
			end
		end
		// two-bit code holds two illegal values
		default: begin
			state_d = NPTX_IDLE;
		end
	endcase
end

always_ff @(posedge sys_clk or negedge rstN) begin
	if (!rstN) begin
		state_q <= NPTX_IDLE;
	end else begin
		state_q <= state_d;
	end
end

////////////////////////////////////////////////////////////////////////////////
// outgoing word and its valid
always_comb begin
	txWord_d = txWord_q;
	// valid tracks the send state, up to and including the cycle with pageDone
	txValid_d = txValid_q;
	if (pageStart) begin
		// snapshot: a write landing mid-page only reaches the following page
		txWord_d = nextWord;
		txValid_d = 1'b1;
	end else if (pageEnd) begin
		txValid_d = 1'b0;
	end
end

always_ff @(posedge sys_clk or negedge rstN) begin
	if (!rstN) begin
		txWord_q <= 16'h0000;
		txValid_q <= 1'b0;
	end else begin
		txWord_q <= txWord_d;
		txValid_q <= txValid_d;
	end
end

////////////////////////////////////////////////////////////////////////////////
// outputs come straight from flip-flops
assign mgmtRdData = rdData_q;
assign mgmtRdValid = rdValid_q;
assign txPageWord = txWord_q;
assign txPageValid = txValid_q;

endmodule : nptx_next_page_tx
`default_nettype wire

// [verif/nptx_chk_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module nptx_chk(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic mgmtRead,
	input wire logic [15:0] mgmtRdData,
	input wire logic mgmtRdValid,
	input wire logic pageRequest,
	input wire logic partnerNextPageAble,
	input wire logic pageDone,
	input wire logic [15:0] txPageWord,
	input wire logic txPageValid
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	property p_rv; mgmtRead |=> mgmtRdValid; endproperty
	a_rv: assert property (p_rv) else $error("no read answer");
	property p_nrv; !mgmtRead |=> !mgmtRdValid; endproperty
	a_nrv: assert property (p_nrv) else $error("stray read answer");
	property p_r14; mgmtRdValid |-> !mgmtRdData[14]; endproperty
	a_r14: assert property (p_r14) else $error("read bit14 set");
	property p_t14; txPageValid |-> !txPageWord[14]; endproperty
	a_t14: assert property (p_t14) else $error("sent bit14 set");
	property p_hold; txPageValid && !pageDone |=> txPageValid && $stable(txPageWord); endproperty
	a_hold: assert property (p_hold) else $error("word moved");
	property p_able; $rose(txPageValid) |-> $past(pageRequest && partnerNextPageAble); endproperty
	a_able: assert property (p_able) else $error("page without able");
	property p_idle; !txPageValid && !(pageRequest && partnerNextPageAble) |=> !txPageValid; endproperty
	a_idle: assert property (p_idle) else $error("page from idle");
	property p_end; txPageValid && pageDone |=> !txPageValid; endproperty
	a_end: assert property (p_end) else $error("page not ended");
	cover property ($rose(txPageValid));
	cover property (txPageValid && pageDone);
	cover property (mgmtRdValid && mgmtRdData[11]);
endmodule : nptx_chk
bind nptx_next_page_tx nptx_chk u_nptx_chk(
	.sys_clk(sys_clk),
	.reset_n(reset_n),
	.mgmtRead(mgmtRead),
	.mgmtRdData(mgmtRdData),
	.mgmtRdValid(mgmtRdValid),
	.pageRequest(pageRequest),
	.partnerNextPageAble(partnerNextPageAble),
	.pageDone(pageDone),
	.txPageWord(txPageWord),
	.txPageValid(txPageValid)
);
`default_nettype wire

// [verif/nptx_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module nptx_partner(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic txPageValid,
	output var logic pageDone
);
	// one cycle per word keeps the exchange short
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) pageDone <= 1'b0;
		else pageDone <= txPageValid && !pageDone;
	end
endmodule : nptx_partner
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,s) begin compares++; if ((s) !== (e)) begin err_total++; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module testbench;
	logic sys_clk=0, reset_n=0, mgmtWrite=0, mgmtRead=0, mgmtRdValid, partnerNextPageAble=1, pageDone, txPageValid;
	logic basePageSent=0, basePageBit11=0, pageRequest=0;
	logic [4:0] mgmtAddr=5'h07;
	logic [15:0] mgmtWrData=16'h0000, mgmtRdData, txPageWord;
	int err_total=0, compares=0;
	always #2.5 sys_clk = ~sys_clk;
	nptx_next_page_tx u_nptx_next_page_tx(
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.mgmtAddr(mgmtAddr),
		.mgmtWrite(mgmtWrite),
		.mgmtRead(mgmtRead),
		.mgmtWrData(mgmtWrData),
		.mgmtRdData(mgmtRdData),
		.mgmtRdValid(mgmtRdValid),
		.partnerNextPageAble(partnerNextPageAble),
		.basePageSent(basePageSent),
		.basePageBit11(basePageBit11),
		.pageRequest(pageRequest),
		.pageDone(pageDone),
		.txPageWord(txPageWord),
		.txPageValid(txPageValid)
	);
	nptx_partner u_nptx_partner(
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.txPageValid(txPageValid),
		.pageDone(pageDone)
	);
	//////////////////////////////////////////
	task automatic wr(input logic [15:0] d);
		mgmtAddr = 5'h07;
		mgmtWrData = d;
		mgmtWrite = 1;
		@(negedge sys_clk) mgmtWrite = 0;
		@(negedge sys_clk);
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		mgmtAddr = a;
		mgmtRead = 1;
		@(negedge sys_clk) mgmtRead = 0;
		`CHK("rd", e, mgmtRdData)
		`CHK("rdvalid", 1'b1, mgmtRdValid)
		@(negedge sys_clk);
	endtask : rd
	task automatic req(input logic [15:0] e);
		pageRequest = 1;
		@(negedge sys_clk) pageRequest = 0;
		`CHK("word", e, txPageWord)
		`CHK("valid", 1'b1, txPageValid)
		@(negedge sys_clk);
	endtask : req
	task automatic t_regs();
		rd(5'h07, 16'h2001);
		wr(16'hbfff);
		rd(5'h07, 16'hb7ff);
		rd(5'h06, 16'h0000);
	endtask : t_regs
	task automatic t_pages();
		basePageBit11 = 1;
		basePageSent = 1;
		@(negedge sys_clk) basePageSent = 0;
		rd(5'h07, 16'hb7ff);
		req(16'hb7ff);
		wr(16'h3123);
		`CHK("snap", 16'hb7ff, txPageWord)
		req(16'h3923);
		// base page lands on the page end edge and must win
		basePageBit11 = 0;
		basePageSent = 1;
		@(negedge sys_clk) basePageSent = 0;
		rd(5'h07, 16'h3923);
		wr(16'h0455);
		req(16'h0c55);
		repeat (3) @(negedge sys_clk);
	endtask : t_pages
	task automatic t_refuse();
		partnerNextPageAble = 0;
		pageRequest = 1;
		@(negedge sys_clk) pageRequest = 0;
		partnerNextPageAble = 1;
		`CHK("refuse", 1'b0, txPageValid)
	endtask : t_refuse
	task automatic finish_test();
		if (err_total == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : finish_test
	initial begin
		repeat (12) @(negedge sys_clk);
		reset_n = 1;
		repeat (3) @(negedge sys_clk);
		t_regs();
		t_pages();
		t_refuse();
		finish_test();
	end
	// far above the few dozen cycles needed
	initial begin
		#5000;
		err_total++;
		finish_test();
	end
endmodule : testbench
`default_nettype wire
